// ---- rcl_pkg.sv ----
// shared constants and types of the retimer configuration loader
package rcl_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int CHANNELS = 4;
  localparam int STRAP_W = 4;
  localparam int EYE_W = 8;
  localparam int CFG_BYTES = 8;

  // ****************************************
  // addresses
  // ****************************************
  localparam logic [6:0] BASE_ADDR7 = 7'h18;
  localparam logic [7:0] TEST_WRITE_ADDR = 8'h30;
  localparam logic [7:0] EEPROM_READ_ADDR = 8'hA1;

  // ****************************************
  // timing
  // ****************************************
  localparam int REF_CLK_KHZ = 10000;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * REF_CLK_KHZ + 999999) / 1000000;
  localparam int SETTLE_W = 8;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(STRAP_SETTLE_CYC - 1);

  // ****************************************
  // pin sample vector layout
  // ****************************************
  localparam int PIN_MODE = 0;
  localparam int PIN_REQ = 1;
  localparam int PIN_STRAP = 2;
  localparam int PIN_SIG = PIN_STRAP + STRAP_W;
  localparam int PIN_LOCK = PIN_SIG + CHANNELS;
  localparam int PIN_W = PIN_LOCK + CHANNELS;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_SETTLE, ST_WAIT_REQ, ST_LOADING, ST_SLAVE} rcl_phase_t;
  typedef enum logic [1:0] {LK_IDLE, LK_START, LK_SHIFT, LK_STOP} rcl_link_t;

  typedef struct packed {
    logic [CHANNELS-1:0] lost_signal;
    logic [CHANNELS-1:0] lost_lock;
    logic [CHANNELS-1:0] eye_low;
  } rcl_irq_info_t;

  typedef struct packed {
    logic [7:0] write_addr;
    logic [7:0] read_addr;
  } rcl_addr_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } rcl_bus_drive_t;

endpackage

// ---- rcl_eeprom_reader.sv ----
// eeprom read engine on the serial bus clock domain
`timescale 1ns/1ps
module rcl_eeprom_reader import rcl_pkg::*; (
  input wire logic link_clk, // serial bus timing clock
  input wire logic reset, // core reset, resynchronised here
  input wire logic start_tgl, // toggles once per load request
  output logic done_tgl, // toggles once per finished load
  output logic [CFG_BYTES-1:0][7:0] cfg_bytes, // bytes read, stable after done
  input wire logic serial_bus_data_in, // data pin level
  output rcl_bus_drive_t drive // open-drain enables, high pulls low
);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic sda_s1;
    logic sda_s2;
    rcl_link_t st;
    logic [1:0] phase;
    logic [3:0] bit_cnt;
    logic [$clog2(CFG_BYTES+1)-1:0] byte_cnt;
    logic is_addr;
    logic [7:0] sh;
    logic [CFG_BYTES-1:0][7:0] cfg;
    logic done_tgl;
    rcl_bus_drive_t drv;
  } lk_state_t;

  lk_state_t s_q;
  lk_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rst_s1 = reset;
    s_d.rst_s2 = s_q.rst_s1;
    s_d.req_s1 = start_tgl;
    s_d.req_s2 = s_q.req_s1;
    s_d.req_s3 = s_q.req_s2;
    s_d.sda_s1 = serial_bus_data_in;
    s_d.sda_s2 = s_q.sda_s1;
    s_d.phase = s_q.phase + 2'h1;
    unique case (s_q.st)
      LK_IDLE: begin
        s_d.phase = 2'h0;
        s_d.drv = '0;
        if (s_q.req_s2 ^ s_q.req_s3) begin
          s_d.st = LK_START;
        end
      end
      LK_START: begin
        // data falls while clock high, then clock falls
        if (s_q.phase == 2'h1) s_d.drv.sda_oe = 1'b1;
        if (s_q.phase == 2'h3) begin
          s_d.drv.scl_oe = 1'b1;
          s_d.st = LK_SHIFT;
          s_d.sh = EEPROM_READ_ADDR;
          s_d.is_addr = 1'b1;
          s_d.bit_cnt = 4'h0;
          s_d.byte_cnt = '0;
        end
      end
      LK_SHIFT: begin
        unique case (s_q.phase)
          2'h0: begin
            s_d.drv.scl_oe = 1'b1;
            if (s_q.bit_cnt == 4'h8) begin
              // ack own read bytes, nack the last one
              s_d.drv.sda_oe = !s_q.is_addr && (32'(s_q.byte_cnt) != CFG_BYTES - 1);
            end else begin
              s_d.drv.sda_oe = s_q.is_addr & ~s_q.sh[7];
            end
          end
          2'h1: s_d.drv.scl_oe = 1'b0;
          2'h2: s_d.drv.scl_oe = 1'b0;
          2'h3: begin
            s_d.drv.scl_oe = 1'b1;
            if (s_q.bit_cnt == 4'h8) begin
              s_d.bit_cnt = 4'h0;
              if (s_q.is_addr) begin
                s_d.is_addr = 1'b0;
              end else begin
                s_d.cfg[s_q.byte_cnt[$clog2(CFG_BYTES)-1:0]] = s_q.sh;
                s_d.byte_cnt = s_q.byte_cnt + 1'b1;
                if (32'(s_q.byte_cnt) == CFG_BYTES - 1) s_d.st = LK_STOP;
              end
            end else begin
              s_d.sh = {s_q.sh[6:0], s_q.sda_s2};
              s_d.bit_cnt = s_q.bit_cnt + 4'h1;
            end
          end
        endcase
      end
      LK_STOP: begin
        // data rises while clock high, bus then free
        if (s_q.phase == 2'h0) s_d.drv = '{scl_oe: 1'b1, sda_oe: 1'b1};
        if (s_q.phase == 2'h1) s_d.drv.scl_oe = 1'b0;
        if (s_q.phase == 2'h3) begin
          s_d.drv.sda_oe = 1'b0;
          s_d.done_tgl = ~s_q.done_tgl;
          s_d.st = LK_IDLE;
        end
      end
    endcase
    if (s_q.rst_s2) begin
      s_d.st = LK_IDLE;
      s_d.drv = '0;
      s_d.done_tgl = 1'b0;
      s_d.req_s3 = s_q.req_s2;
    end
  end

  always_ff @(posedge link_clk) begin
    s_q <= s_d;
  end

  assign done_tgl = s_q.done_tgl;
  assign cfg_bytes = s_q.cfg;
  assign drive = s_q.drv;

endmodule

// ---- rcl_config_loader.sv ----
// power-up configuration, load chaining, lock pins and interrupt of the retimer
`timescale 1ns/1ps
//
// Operation
// - sample mode pin at power-up, float=master
// - master mode: low load request starts read
// - drive load-done low when read completes
// - bus master only while loading, then slave
// - slave with request high: fixed address 0x30
// - latch four address straps at power-up
// - address 0x18 plus strap, shifted, lsb read
// - address byte lsb: 0 write, 1 read
// - straps become per-channel lock outputs
// - interrupt is active-low open-drain
// - signal or lock loss interrupts unmasked once straps latch
// - eye opening interrupt, off at reset
// - capture interrupt cause for readout
// - repeat reference clock on output pin
// - set completion status when read done
module rcl_config_loader import rcl_pkg::*; (
  input wire logic ref_clk, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic link_clk, // serial bus timing clock
  input wire logic config_mode_select, // mode pin, high=slave, float reads low
  input wire logic load_request_n, // load request pin
  output logic load_done_n, // load finished, low once done
  output logic load_complete, // completion status bit
  input wire logic [STRAP_W-1:0] strap_lock_in, // strap and lock pin levels
  output logic [STRAP_W-1:0] strap_lock_out, // lock level driven out
  output logic [STRAP_W-1:0] strap_lock_oe, // lock pins driven
  input wire logic [CHANNELS-1:0] chan_signal_detect, // per-channel signal present
  input wire logic [CHANNELS-1:0] chan_locked, // per-channel data lock
  input wire logic [CHANNELS*EYE_W-1:0] horizontal_eye_opening, // per-channel, core clock
  input wire logic [CHANNELS*EYE_W-1:0] vertical_eye_opening, // per-channel, core clock
  input wire logic [CHANNELS*EYE_W-1:0] eye_h_threshold, // per-channel limit
  input wire logic [CHANNELS*EYE_W-1:0] eye_v_threshold, // per-channel limit
  input wire logic [CHANNELS-1:0] eye_irq_enable, // per-channel eye interrupt on
  input wire logic irq_clear, // pulse, clears captured causes
  output rcl_irq_info_t irq_info, // captured interrupt causes
  output logic int_n_out, // interrupt pin level when driven
  output logic int_n_oe, // interrupt pin pulled low
  output logic bus_slave_active, // address valid, slave answering
  output logic master_mode, // latched mode, high=master
  output rcl_addr_t slave_addr, // latched write and read address
  output logic [CFG_BYTES-1:0][7:0] loaded_config, // bytes taken from the eeprom
  output logic serial_bus_clock_out, // bus clock level when driven
  output logic serial_bus_clock_oe, // bus clock pulled low
  input wire logic serial_bus_data_in, // bus data level
  output logic serial_bus_data_out, // bus data level when driven
  output logic serial_bus_data_oe, // bus data pulled low
  input wire logic ref_clock_input, // reference clock in
  output logic ref_clock_repeat // reference clock copy out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic done_s1;
    logic done_s2;
    logic done_s3;
    rcl_phase_t phase;
    logic [SETTLE_W-1:0] settle_cnt;
    logic master;
    logic addr_valid;
    rcl_addr_t addr;
    logic start_tgl;
    logic load_done_n;
    logic load_complete;
    logic [CHANNELS-1:0] sig_prev;
    logic [CHANNELS-1:0] lock_prev;
    logic [CHANNELS-1:0] eye_prev;
    rcl_irq_info_t info;
    logic int_oe;
    logic [STRAP_W-1:0] lock_oe;
    logic [STRAP_W-1:0] lock_out;
    logic [CFG_BYTES-1:0][7:0] cfg;
  } rcl_state_t;

  rcl_state_t s_q;
  rcl_state_t s_d;

  logic done_tgl;
  logic [CFG_BYTES-1:0][7:0] link_cfg;
  rcl_bus_drive_t link_drive;
  logic [CHANNELS-1:0] eye_low_now;

  // ****************************************
  // address from strap
  // ****************************************
  function automatic rcl_addr_t strap_address(input logic [STRAP_W-1:0] strap);
    logic [6:0] a7;
    a7 = BASE_ADDR7 + {3'h0, strap};
    strap_address.write_addr = {a7, 1'b0};
    strap_address.read_addr = {a7, 1'b1};
  endfunction

  if (STRAP_SETTLE_CYC < 1 || STRAP_SETTLE_CYC > 2 ** SETTLE_W) begin : g_settle_check
    $error("strap settle count does not fit its counter");
  end

  // ****************************************
  // eye opening compare
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_eye
      assign eye_low_now[ch] = eye_irq_enable[ch] &&
        ((horizontal_eye_opening[ch*EYE_W +: EYE_W] < eye_h_threshold[ch*EYE_W +: EYE_W]) ||
         (vertical_eye_opening[ch*EYE_W +: EYE_W] < eye_v_threshold[ch*EYE_W +: EYE_W]));
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [CHANNELS-1:0] sig_now;
    logic [CHANNELS-1:0] lock_now;
    rcl_irq_info_t events;
    sig_now = s_q.pin_s2[PIN_SIG +: CHANNELS];
    lock_now = s_q.pin_s2[PIN_LOCK +: CHANNELS];
    events = '0;
    s_d = s_q;
    s_d.pin_s1 = {chan_locked, chan_signal_detect, strap_lock_in, load_request_n, config_mode_select};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.done_s1 = done_tgl;
    s_d.done_s2 = s_q.done_s1;
    s_d.done_s3 = s_q.done_s2;
    s_d.sig_prev = sig_now;
    s_d.lock_prev = lock_now;
    s_d.eye_prev = eye_low_now;

    unique case (s_q.phase)
      ST_SETTLE: begin
        s_d.settle_cnt = s_q.settle_cnt + 1'b1;
        if (s_q.settle_cnt == SETTLE_LAST) begin
          s_d.master = ~s_q.pin_s2[PIN_MODE];
          s_d.addr = strap_address(s_q.pin_s2[PIN_STRAP +: STRAP_W]);
          if (s_q.pin_s2[PIN_MODE] && s_q.pin_s2[PIN_REQ]) begin
            s_d.addr.write_addr = TEST_WRITE_ADDR;
            s_d.addr.read_addr = {TEST_WRITE_ADDR[7:1], 1'b1};
          end
          s_d.lock_oe = '1;
          s_d.phase = s_q.pin_s2[PIN_MODE] ? ST_SLAVE : ST_WAIT_REQ;
          s_d.addr_valid = s_q.pin_s2[PIN_MODE];
        end
      end
      ST_WAIT_REQ: begin
        if (!s_q.pin_s2[PIN_REQ]) begin
          s_d.start_tgl = ~s_q.start_tgl;
          s_d.phase = ST_LOADING;
        end
      end
      ST_LOADING: begin
        if (s_q.done_s2 ^ s_q.done_s3) begin
          s_d.cfg = link_cfg;
          s_d.load_done_n = 1'b0;
          s_d.load_complete = 1'b1;
          s_d.addr_valid = 1'b1;
          s_d.phase = ST_SLAVE;
        end
      end
      ST_SLAVE: begin
        s_d.phase = ST_SLAVE;
      end
    endcase

    // lock level on the former strap pins
    s_d.lock_out = s_q.lock_oe & lock_now;

    events.lost_signal = s_q.sig_prev & ~sig_now;
    events.lost_lock = s_q.lock_prev & ~lock_now;
    events.eye_low = eye_low_now & ~s_q.eye_prev;
    if (s_q.phase == ST_SETTLE) events = '0;
    // a cause arriving with the clear is kept
    s_d.info = (irq_clear ? rcl_irq_info_t'('0) : s_q.info) | events;
    s_d.int_oe = |s_d.info;

    if (reset) begin
      s_d.phase = ST_SETTLE;
      s_d.settle_cnt = '0;
      s_d.master = 1'b0;
      s_d.addr_valid = 1'b0;
      s_d.addr = '0;
      s_d.load_done_n = 1'b1;
      s_d.load_complete = 1'b0;
      s_d.info = '0;
      s_d.int_oe = 1'b0;
      s_d.lock_oe = '0;
      s_d.lock_out = '0;
      s_d.cfg = '0;
      s_d.start_tgl = 1'b0;
      s_d.done_s3 = s_q.done_s2;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_q <= s_d;
  end

  // ****************************************
  // eeprom read engine
  // ****************************************
  rcl_eeprom_reader u_reader (
    .link_clk(link_clk),
    .reset(reset),
    .start_tgl(s_q.start_tgl),
    .done_tgl(done_tgl),
    .cfg_bytes(link_cfg),
    .serial_bus_data_in(serial_bus_data_in),
    .drive(link_drive)
  );

  // ****************************************
  // outputs
  // ****************************************
  assign load_done_n = s_q.load_done_n;
  assign load_complete = s_q.load_complete;
  assign strap_lock_out = s_q.lock_out;
  assign strap_lock_oe = s_q.lock_oe;
  assign irq_info = s_q.info;
  assign int_n_out = 1'b0;
  assign int_n_oe = s_q.int_oe;
  assign bus_slave_active = s_q.addr_valid;
  assign master_mode = s_q.master;
  assign slave_addr = s_q.addr;
  assign loaded_config = s_q.cfg;
  // open-drain, only pulled while the load engine owns the bus
  assign serial_bus_clock_out = 1'b0;
  assign serial_bus_clock_oe = link_drive.scl_oe;
  assign serial_bus_data_out = 1'b0;
  assign serial_bus_data_oe = link_drive.sda_oe;
  // plain buffer, a flop cannot carry the faster clock
  assign ref_clock_repeat = ref_clock_input;

endmodule

// ---- rcl_eeprom_model.sv ----
// serial eeprom model answering the loader's configuration read
`timescale 1ns/1ps
module rcl_eeprom_model import rcl_pkg::*; (
  input wire logic scl, // bus clock level
  input wire logic sda, // bus data level
  output logic sda_pull // high pulls data low
);
  // ****************************************
  // frame tracking
  // ****************************************
  logic active = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] d;
  int cnt = 0;
  int j;
  initial sda_pull = 1'b0;
  always @(negedge sda) begin
    if (scl) begin
      active = 1'b1;
      cnt = 0;
    end
  end
  always @(posedge sda) begin
    if (scl) begin
      active = 1'b0;
    end
  end
  always @(posedge scl) begin
    if (active && cnt < 8) begin
      addr = {addr[6:0], sda};
    end
    cnt = cnt + 1;
  end
  // ****************************************
  // answer: ack own address, then bytes msb first
  // ****************************************
  always @(negedge scl) begin
    j = cnt - 9;
    d = 8'h3C + 8'((j / 9) * 17);
    if (!active) begin
      sda_pull = 1'b0;
    end else if (cnt == 8) begin
      sda_pull = (addr == EEPROM_READ_ADDR);
    end else if (cnt >= 9 && addr[0] && j % 9 < 8 && j / 9 < CFG_BYTES) begin
      sda_pull = !d[7 - j % 9];
    end else begin
      sda_pull = 1'b0;
    end
  end
endmodule

// ---- rcl_config_loader_sva.sv ----
// assertions on the configuration loader ports
`timescale 1ns/1ps
module rcl_config_loader_sva import rcl_pkg::*; (
  input wire logic ref_clk, // clock
  input wire logic reset, // reset
  input wire logic load_done_n, // out
  input wire logic load_complete, // out
  input wire logic [STRAP_W-1:0] strap_lock_out, // out
  input wire logic [STRAP_W-1:0] strap_lock_oe, // out
  input wire logic [CHANNELS-1:0] chan_locked, // in
  input wire logic [CHANNELS-1:0] eye_irq_enable, // in
  input wire rcl_irq_info_t irq_info, // out
  input wire logic int_n_out, // out
  input wire logic int_n_oe, // out
  input wire logic bus_slave_active, // out
  input wire logic master_mode, // out
  input wire rcl_addr_t slave_addr, // out
  input wire logic serial_bus_clock_oe, // out
  input wire logic serial_bus_data_oe, // out
  input wire logic ref_clock_input, // in
  input wire logic ref_clock_repeat // out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ****************************************
  // sequences
  // ****************************************
  sequence s_latched;
    strap_lock_oe[0] && $past(strap_lock_oe[0]) && $past(strap_lock_oe[0], 4);
  endsequence
  sequence s_lock_loss;
    s_latched ##0 $past(chan_locked[0], 4) && !$past(chan_locked[0], 3);
  endsequence
  // ****************************************
  // properties
  // ****************************************
  property p_done_sticky; !load_done_n |=> !load_done_n; endproperty
  property p_done_status; load_complete == !load_done_n; endproperty
  property p_release; !load_done_n |-> !serial_bus_clock_oe && !serial_bus_data_oe && bus_slave_active; endproperty
  property p_slave_quiet;
    strap_lock_oe[0] && !master_mode |-> load_done_n && bus_slave_active && !serial_bus_clock_oe;
  endproperty
  property p_addr;
    strap_lock_oe[0] |-> slave_addr.read_addr == {slave_addr.write_addr[7:1], 1'b1} && !slave_addr.write_addr[0];
  endproperty
  property p_latch_hold; strap_lock_oe[0] |=> $stable(slave_addr) && $stable(master_mode) && strap_lock_oe[0]; endproperty
  property p_unlatched; !strap_lock_oe[0] |-> strap_lock_out == 4'h0 && !int_n_oe && load_done_n; endproperty
  property p_lock_follow; s_latched |-> strap_lock_out == $past(chan_locked, 3); endproperty
  property p_irq_pin; int_n_oe == (|irq_info) && int_n_out == 1'b0; endproperty
  property p_lost_lock; s_lock_loss |-> irq_info.lost_lock[0]; endproperty
  property p_eye_off;
    !$past(eye_irq_enable[0]) && !$past(eye_irq_enable[0], 2) && !$past(eye_irq_enable[0], 3)
      && !$past(irq_info.eye_low[0]) |-> !irq_info.eye_low[0];
  endproperty
  property p_refclk; ref_clock_repeat == ref_clock_input; endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("load done released");
  a_done_status: assert property (p_done_status) else $error("status differs from done");
  a_release: assert property (p_release) else $error("bus held after load");
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave mode loaded");
  a_addr: assert property (p_addr) else $error("address pair wrong");
  a_latch_hold: assert property (p_latch_hold) else $error("latched values moved");
  a_unlatched: assert property (p_unlatched) else $error("activity before latch");
  a_lock_follow: assert property (p_lock_follow) else $error("lock pin wrong");
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt pin wrong");
  a_lost_lock: assert property (p_lost_lock) else $error("lock loss missed");
  a_eye_off: assert property (p_eye_off) else $error("eye irq while off");
  a_refclk: assert property (p_refclk) else $error("clock copy wrong");
endmodule
bind rcl_config_loader rcl_config_loader_sva u_rcl_config_loader_sva (.ref_clk, .reset, .load_done_n,
  .load_complete, .strap_lock_out, .strap_lock_oe, .chan_locked, .eye_irq_enable, .irq_info, .int_n_out,
  .int_n_oe, .bus_slave_active, .master_mode, .slave_addr, .serial_bus_clock_oe, .serial_bus_data_oe,
  .ref_clock_input, .ref_clock_repeat);

// ---- rcl_config_loader_tb.sv ----
// self-checking bench of the configuration loader
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module rcl_config_loader_tb import rcl_pkg::*; ;
  logic ref_clk = 0, link_clk = 0, reset = 1, ref_clock_input = 0, irq_clear = 0;
  logic config_mode_select = 0, load_request_n = 1;
  logic [3:0] strap = 0, chan_signal_detect = 0, chan_locked = 0, eye_irq_enable = 0;
  logic [31:0] horizontal_eye_opening = 32'h80808080, vertical_eye_opening = 32'h80808080;
  logic [31:0] eye_h_threshold = 32'h40404040, eye_v_threshold = 32'h40404040;
  logic load_done_n, load_complete, int_n_out, int_n_oe, bus_slave_active, master_mode, ref_clock_repeat;
  logic [3:0] strap_lock_out, strap_lock_oe;
  rcl_irq_info_t irq_info;
  rcl_addr_t slave_addr;
  logic [CFG_BYTES-1:0][7:0] loaded_config;
  logic serial_bus_clock_out, serial_bus_clock_oe, serial_bus_data_out, serial_bus_data_oe, sda_pull;
  wire scl = !serial_bus_clock_oe;
  wire sda = !(serial_bus_data_oe | sda_pull);
  wire [3:0] strap_pin = (strap_lock_oe & strap_lock_out) | (~strap_lock_oe & strap);
  int errors = 0, n_checks = 0, cyc = 0;
  rcl_config_loader u_rcl_config_loader (.ref_clk, .reset, .link_clk, .config_mode_select, .load_request_n,
    .load_done_n, .load_complete, .strap_lock_in(strap_pin), .strap_lock_out, .strap_lock_oe,
    .chan_signal_detect, .chan_locked, .horizontal_eye_opening, .vertical_eye_opening, .eye_h_threshold,
    .eye_v_threshold, .eye_irq_enable, .irq_clear, .irq_info, .int_n_out, .int_n_oe, .bus_slave_active,
    .master_mode, .slave_addr, .loaded_config, .serial_bus_clock_out, .serial_bus_clock_oe,
    .serial_bus_data_in(sda), .serial_bus_data_out, .serial_bus_data_oe, .ref_clock_input, .ref_clock_repeat);
  rcl_eeprom_model u_rcl_eeprom_model (.scl(scl), .sda(sda), .sda_pull(sda_pull));
  // ****************************************
  // clocks and timeout
  // ****************************************
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end
  initial begin
    #3;
    forever #20 ref_clock_input = ~ref_clock_input;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      errors++;
      close_out();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task step(input int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask
  task clear_irq;
    irq_clear = 1;
    step(1);
    irq_clear = 0;
    step(1);
  endtask
  task power_up(input logic m, input logic r, input logic [3:0] s);
    config_mode_select = m;
    load_request_n = r;
    strap = s;
    reset = 1;
    step(6);
    reset = 0;
    step(11);
    `CHK(strap_lock_oe, 4'hF)
    `CHK(master_mode, !m)
    `CHK(ref_clock_repeat, ref_clock_input)
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_addr(input logic m, input logic r, input logic [3:0] s, input logic [7:0] w);
    power_up(m, r, s);
    `CHK(slave_addr.write_addr, w)
    `CHK(slave_addr.read_addr, w | 8'h01)
    `CHK(bus_slave_active, m)
    `CHK(load_done_n, 1'b1)
  endtask
  task t_master;
    int n;
    t_addr(0, 1, 4'hF, 8'h4E);
    step(50);
    `CHK(load_done_n, 1'b1)
    load_request_n = 0;
    n = 0;
    while (load_done_n !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    `CHK(load_done_n, 1'b0)
    `CHK(load_complete, 1'b1)
    `CHK(bus_slave_active, 1'b1)
    for (int i = 0; i < CFG_BYTES; i++) begin
      `CHK(loaded_config[i], 8'h3C + 8'(i * 17))
    end
    load_request_n = 1;
    step(20);
    `CHK(load_done_n, 1'b0)
    `CHK(serial_bus_clock_oe, 1'b0)
    `CHK({serial_bus_clock_out, serial_bus_data_out, serial_bus_data_oe}, 3'h0)
  endtask
  task t_irq;
    power_up(1, 0, 4'h3);
    chan_signal_detect = 4'hF;
    chan_locked = 4'hF;
    step(5);
    `CHK(strap_lock_out, 4'hF)
    `CHK(irq_info, 12'h000)
    chan_locked = 4'hA;
    step(5);
    `CHK(irq_info.lost_lock, 4'h5)
    `CHK(int_n_oe, 1'b1)
    `CHK(strap_lock_out, 4'hA)
    clear_irq();
    `CHK(int_n_oe, 1'b0)
    chan_signal_detect = 4'hD;
    step(5);
    `CHK(irq_info.lost_signal, 4'h2)
    clear_irq();
    horizontal_eye_opening = 32'h10101010;
    step(5);
    `CHK(irq_info.eye_low, 4'h0)
    horizontal_eye_opening = 32'h80808080;
    step(3);
    eye_irq_enable = 4'h8;
    step(3);
    vertical_eye_opening[31:24] = 8'h20;
    step(5);
    `CHK(irq_info.eye_low, 4'h8)
    `CHK(int_n_oe, 1'b1)
    // loss arriving in the clear cycle survives it
    chan_signal_detect = 4'h5;
    step(2);
    clear_irq();
    `CHK(irq_info, 12'h800)
  endtask
  task close_out;
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    for (int s = 0; s < 16; s++) begin
      t_addr(1, 0, 4'(s), {7'h18 + 7'(s), 1'b0});
    end
    t_addr(1, 1, 4'h9, 8'h30);
    t_master();
    t_irq();
    close_out();
  end
endmodule
